// file: core/uoi_pkg.sv
package uoi_pkg;

    // Register offsets (byte addresses)
    localparam logic [11:0] UOI_STS_OFS   = 12'h014;
    localparam logic [11:0] UOI_MSK_OFS   = 12'h018;
    localparam logic [11:0] UOI_CTL_OFS   = 12'h040;

    // Address pages that belong to one operating mode only
    localparam logic [1:0]  UOI_HOST_PAGE = 2'h1;
    localparam logic [1:0]  UOI_DEV_PAGE  = 2'h2;

    // Status register layout
    localparam int UOI_B_WAKE   = 31;
    localparam int UOI_B_SREQ   = 30;
    localparam int UOI_B_DISC   = 29;
    localparam int UOI_B_CID    = 28;
    localparam int UOI_B_PTXE   = 26;
    localparam int UOI_B_CHAN   = 25;
    localparam int UOI_B_PORT   = 24;
    localparam int UOI_B_INCP   = 21;
    localparam int UOI_B_INCI   = 20;
    localparam int UOI_B_OEP    = 19;
    localparam int UOI_B_IEP    = 18;
    localparam int UOI_B_PERIODIC_FRAME_END_FLAG   = 15;
    localparam int UOI_B_ISODRP = 14;
    localparam int UOI_B_ENUM   = 13;
    localparam int UOI_B_BRST   = 12;
    localparam int UOI_B_SUSP   = 11;
    localparam int UOI_B_EARLY_SUSPEND_FLAG  = 10;
    localparam int UOI_B_GONAK  = 7;
    localparam int UOI_B_GINAK  = 6;
    localparam int UOI_B_NPTXE  = 5;
    localparam int UOI_B_RXNE   = 4;
    localparam int UOI_B_SOF    = 3;
    localparam int UOI_B_OTG    = 2;
    localparam int UOI_B_WRONG_MODE_ACCESS_FLAG   = 1;
    localparam int UOI_B_ROLE   = 0;

    localparam logic [31:0] UOI_STS_RST   = 32'h04000020;
    localparam logic [31:0] UOI_W1C_MASK  = 32'hf030fc0a;
    localparam logic [31:0] UOI_VALID_MSK = 32'hf73cfcff;
    localparam logic [31:0] UOI_MSK_RST   = 32'h00000000;

    // Control register layout
    localparam int UOI_C_PLVL  = 0;
    localparam int UOI_C_NPLVL = 1;
    localparam int UOI_C_SGO   = 2;
    localparam int UOI_C_CGO   = 3;
    localparam int UOI_C_SGI   = 4;
    localparam int UOI_C_CGI   = 5;
    localparam logic [31:0] UOI_CTL_STORE = 32'h00000003;

    // Timing
    localparam int UOI_CLK_NS   = 100;
    localparam int UOI_IDLE_NS  = 3000000;
    localparam int UOI_IDLE_CYC = (UOI_IDLE_NS + UOI_CLK_NS - 1) / UOI_CLK_NS;

    typedef struct packed {
        logic resume;
        logic rwakeup;
        logic sess_req;
        logic vbus_valid;
        logic disconnect;
        logic incomplete_periodic;
        logic periodic_point;
        logic iso_drop;
        logic enum_done;
        logic bus_reset;
        logic sof;
    } uoi_evt_t;

    typedef struct packed {
        logic chan_pending;
        logic port_pending;
        logic out_ep_pending;
        logic in_ep_pending;
        logic iso_out_open;
        logic iso_in_open;
        logic ptx_half;
        logic ptx_empty;
        logic ptx_queue_room;
        logic nptx_half;
        logic nptx_empty;
        logic nptx_queue_room;
        logic rx_pkt_waiting;
        logic otg_pending;
        logic ep_stall;
    } uoi_lvl_t;

endpackage : uoi_pkg

// file: core/uoi_core_int.sv
`timescale 1ns/10ps
module uoi_core_int
    import uoi_pkg::*;
#(
    parameter int SUSP_CYCLES = UOI_IDLE_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata_ff,
    input  wire logic        id_pin,
    input  wire logic        line_idle_pin,
    input  wire uoi_evt_t    evt,
    input  wire uoi_lvl_t    lvl,
    output logic             irq_ff,
    output logic             suspended_ff,
    output logic             out_nak_ff,
    output logic             in_nak_ff,
    output logic             stall_hs_ff,
    output logic             nak_hs_ff
);

    localparam int CW = $clog2(SUSP_CYCLES + 1);
    localparam logic [CW-1:0] SUSP_LAST = CW'(SUSP_CYCLES - 1);

    logic [31:0]   status_ff;
    logic [31:0]   mask_ff;
    logic [31:0]   ctl_ff;
    logic          id_s1_ff;
    logic          id_s2_ff;
    logic          id_prev_ff;
    logic          id_seen_ff;
    logic          idle_s1_ff;
    logic          idle_s2_ff;
    logic [CW-1:0] idle_cnt_ff;
    logic          sgo_req_ff;
    logic          sgi_req_ff;

    // Decode
    wire        host      = ~id_s2_ff;
    wire        dev       = id_s2_ff;
    wire        acc       = reg_wr | reg_rd;
    wire        hit_sts   = reg_addr == UOI_STS_OFS;
    wire        hit_msk   = reg_addr == UOI_MSK_OFS;
    wire        hit_ctl   = reg_addr == UOI_CTL_OFS;
    wire [1:0]  page      = reg_addr[11:10];
    wire        wrong_mode = acc & ((dev & (page == UOI_HOST_PAGE))
                                  | (host & (page == UOI_DEV_PAGE)));
    wire        wr_sts    = reg_wr & hit_sts;
    wire        wr_msk    = reg_wr & hit_msk;
    wire        wr_ctl    = reg_wr & hit_ctl;
    wire [31:0] w1c_clr   = wr_sts ? (reg_wdata & UOI_W1C_MASK) : 32'h00000000;
    wire        sgo_wr    = wr_ctl & reg_wdata[UOI_C_SGO];
    wire        cgo_wr    = wr_ctl & reg_wdata[UOI_C_CGO];
    wire        sgi_wr    = wr_ctl & reg_wdata[UOI_C_SGI];
    wire        cgi_wr    = wr_ctl & reg_wdata[UOI_C_CGI];

    // Suspend detection on the synchronised idle level
    wire        idle_full = idle_cnt_ff == SUSP_LAST;
    wire        susp_hit  = dev & idle_s2_ff & idle_full & ~suspended_ff;
    wire [CW-1:0] nxt_idle_cnt = (~idle_s2_ff | ~dev) ? '0 :
                                 idle_full ? idle_cnt_ff : idle_cnt_ff + CW'(1);
    wire        nxt_suspended = dev & idle_s2_ff & (suspended_ff | idle_full);

    // FIFO readiness with level selects
    wire ptx_lvl  = ctl_ff[UOI_C_PLVL]  ? lvl.ptx_empty  : (lvl.ptx_half  | lvl.ptx_empty);
    wire nptx_lvl = ctl_ff[UOI_C_NPLVL] ? lvl.nptx_empty : (lvl.nptx_half | lvl.nptx_empty);
    wire id_chg   = id_seen_ff & (id_s2_ff != id_prev_ff);

    // Sticky event sources, gated by mode except CID, SOF and the wrong-mode access flag
    logic [31:0] ev_set;
    always_comb begin
        ev_set               = 32'h00000000;
        ev_set[UOI_B_WAKE]   = (dev & evt.resume) | (host & evt.rwakeup);
        ev_set[UOI_B_SREQ]   = (host & evt.sess_req) | (dev & evt.vbus_valid);
        ev_set[UOI_B_DISC]   = host & evt.disconnect;
        ev_set[UOI_B_CID]    = id_chg;
        ev_set[UOI_B_INCP]   = (host & evt.incomplete_periodic)
                             | (dev & evt.periodic_point & lvl.iso_out_open);
        ev_set[UOI_B_INCI]   = dev & evt.periodic_point & lvl.iso_in_open;
        ev_set[UOI_B_PERIODIC_FRAME_END_FLAG]   = dev & evt.periodic_point;
        ev_set[UOI_B_ISODRP] = dev & evt.iso_drop;
        ev_set[UOI_B_ENUM]   = dev & evt.enum_done;
        ev_set[UOI_B_BRST]   = dev & evt.bus_reset;
        ev_set[UOI_B_SUSP]   = susp_hit;
        ev_set[UOI_B_EARLY_SUSPEND_FLAG]  = susp_hit;
        ev_set[UOI_B_SOF]    = evt.sof;
        ev_set[UOI_B_WRONG_MODE_ACCESS_FLAG]   = wrong_mode;
    end

    // Read-only bits follow their sources
    logic [31:0] ro_bits;
    always_comb begin
        ro_bits              = 32'h00000000;
        ro_bits[UOI_B_PTXE]  = host & ptx_lvl & lvl.ptx_queue_room;
        ro_bits[UOI_B_CHAN]  = host & lvl.chan_pending;
        ro_bits[UOI_B_PORT]  = host & lvl.port_pending;
        ro_bits[UOI_B_OEP]   = dev & lvl.out_ep_pending;
        ro_bits[UOI_B_IEP]   = dev & lvl.in_ep_pending;
        ro_bits[UOI_B_GONAK] = out_nak_ff;
        ro_bits[UOI_B_GINAK] = in_nak_ff;
        ro_bits[UOI_B_NPTXE] = host & nptx_lvl & lvl.nptx_queue_room;
        ro_bits[UOI_B_RXNE]  = lvl.rx_pkt_waiting;
        ro_bits[UOI_B_OTG]   = lvl.otg_pending;
        ro_bits[UOI_B_ROLE]  = host;
    end

    // Set wins over a same-cycle clear
    wire [31:0] nxt_status = ((((status_ff & ~w1c_clr) | ev_set) & UOI_W1C_MASK)
                             | ro_bits) & UOI_VALID_MSK;
    wire [31:0] nxt_mask   = wr_msk ? (reg_wdata & UOI_VALID_MSK) : mask_ff;
    wire [31:0] nxt_ctl    = wr_ctl ? (reg_wdata & UOI_CTL_STORE) : ctl_ff;
    wire        nxt_irq    = |(status_ff & mask_ff);
    wire [31:0] nxt_rdata  = ~reg_rd ? 32'h00000000 :
                             hit_sts ? status_ff :
                             hit_msk ? mask_ff :
                             hit_ctl ? ctl_ff : 32'h00000000;

    // Global NAK: request is sampled, then takes effect a cycle later
    wire nxt_sgo_req = dev & ~cgo_wr & (sgo_wr | (sgo_req_ff & ~out_nak_ff));
    wire nxt_out_nak = dev & ~cgo_wr & (out_nak_ff | sgo_req_ff);
    wire nxt_sgi_req = dev & ~cgi_wr & (sgi_wr | (sgi_req_ff & ~in_nak_ff));
    wire nxt_in_nak  = dev & ~cgi_wr & (in_nak_ff | sgi_req_ff);
    wire nxt_stall   = dev & lvl.ep_stall;
    wire nxt_nak_hs  = dev & in_nak_ff & ~lvl.ep_stall;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            id_s1_ff   <= 1'b1;
            id_s2_ff   <= 1'b1;
            idle_s1_ff <= 1'b0;
            idle_s2_ff <= 1'b0;
        end else begin
            id_s1_ff   <= id_pin;
            id_s2_ff   <= id_s1_ff;
            idle_s1_ff <= line_idle_pin;
            idle_s2_ff <= idle_s1_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            id_prev_ff <= 1'b1;
            id_seen_ff <= 1'b0;
        end else begin
            id_prev_ff <= id_s2_ff;
            id_seen_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            status_ff    <= UOI_STS_RST;
            mask_ff      <= UOI_MSK_RST;
            ctl_ff       <= 32'h00000000;
            reg_rdata_ff <= 32'h00000000;
            irq_ff       <= 1'b0;
        end else begin
            status_ff    <= nxt_status;
            mask_ff      <= nxt_mask;
            ctl_ff       <= nxt_ctl;
            reg_rdata_ff <= nxt_rdata;
            irq_ff       <= nxt_irq;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            idle_cnt_ff  <= '0;
            suspended_ff <= 1'b0;
            sgo_req_ff   <= 1'b0;
            out_nak_ff   <= 1'b0;
            sgi_req_ff   <= 1'b0;
            in_nak_ff    <= 1'b0;
            stall_hs_ff  <= 1'b0;
            nak_hs_ff    <= 1'b0;
        end else begin
            idle_cnt_ff  <= nxt_idle_cnt;
            suspended_ff <= nxt_suspended;
            sgo_req_ff   <= nxt_sgo_req;
            out_nak_ff   <= nxt_out_nak;
            sgi_req_ff   <= nxt_sgi_req;
            in_nak_ff    <= nxt_in_nak;
            stall_hs_ff  <= nxt_stall;
            nak_hs_ff    <= nxt_nak_hs;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_sof_write_one;
        reg_wr && hit_sts && reg_wdata[UOI_B_SOF] && !evt.sof;
    endsequence

    sequence s_sgo_then_gap;
        dev && sgo_wr && !cgo_wr ##1 dev && !cgo_wr;
    endsequence

    sequence s_sgi_then_gap;
        dev && sgi_wr && !cgi_wr ##1 dev && !cgi_wr;
    endsequence

    w1c_clear_a: assert property (s_sof_write_one |=> !status_ff[UOI_B_SOF])
        else $error("Start-of-frame flag not cleared by written one");

    w1c_keep_a: assert property (
        (status_ff[UOI_B_BRST] && !(wr_sts && reg_wdata[UOI_B_BRST]))
        |=> status_ff[UOI_B_BRST])
        else $error("Bus reset flag lost without written one");

    set_wins_a: assert property (
        (evt.sof && wr_sts && reg_wdata[UOI_B_SOF]) |=> status_ff[UOI_B_SOF])
        else $error("Start-of-frame event lost to same-cycle clear");

    rx_follow_a: assert property (
        $past(rst_b) |-> status_ff[UOI_B_RXNE] == $past(lvl.rx_pkt_waiting))
        else $error("Receive flag does not follow packet waiting");

    fifo_ro_a: assert property (
        (dev ##1 dev) |-> !status_ff[UOI_B_NPTXE] && !status_ff[UOI_B_PTXE])
        else $error("Host FIFO flag visible in device mode");

    role_bit_a: assert property (
        status_ff[UOI_B_ROLE] == $past(host))
        else $error("Role bit does not match mode");

    wake_flag_a: assert property (
        ((dev && evt.resume) || (host && evt.rwakeup)) |=> status_ff[UOI_B_WAKE])
        else $error("Wakeup event not flagged");

    sreq_flag_a: assert property (
        ((host && evt.sess_req) || (dev && evt.vbus_valid)) |=> status_ff[UOI_B_SREQ])
        else $error("Session request not flagged");

    disc_gate_a: assert property (
        (host && evt.disconnect) |=> status_ff[UOI_B_DISC])
        else $error("Disconnect not flagged in host mode");

    cid_flag_a: assert property (id_chg |=> status_ff[UOI_B_CID])
        else $error("Connector ID change not flagged");

    ptx_level_a: assert property (
        $past(rst_b) |-> status_ff[UOI_B_PTXE]
            == ($past(host) && $past(ptx_lvl) && $past(lvl.ptx_queue_room)))
        else $error("Periodic FIFO empty flag does not follow its source");

    chan_follow_a: assert property (
        $past(rst_b) |-> status_ff[UOI_B_CHAN] == ($past(host) && $past(lvl.chan_pending)))
        else $error("Host channel summary does not follow its source");

    port_follow_a: assert property (
        $past(rst_b) |-> status_ff[UOI_B_PORT] == ($past(host) && $past(lvl.port_pending)))
        else $error("Root port summary does not follow its source");

    incp_host_a: assert property (
        (host && evt.incomplete_periodic) |=> status_ff[UOI_B_INCP])
        else $error("Incomplete periodic transfer not flagged");

    periodic_frame_end_flag_pair_a: assert property (
        (dev && evt.periodic_point && lvl.iso_in_open)
        |=> status_ff[UOI_B_INCI] && status_ff[UOI_B_PERIODIC_FRAME_END_FLAG])
        else $error("Iso IN incomplete not raised with frame end");

    oep_follow_a: assert property (
        $past(rst_b) |-> status_ff[UOI_B_OEP] == ($past(dev) && $past(lvl.out_ep_pending)))
        else $error("OUT endpoint summary does not follow its source");

    iep_follow_a: assert property (
        $past(rst_b) |-> status_ff[UOI_B_IEP] == ($past(dev) && $past(lvl.in_ep_pending)))
        else $error("IN endpoint summary does not follow its source");

    drop_flag_a: assert property (
        (dev && evt.iso_drop) |=> status_ff[UOI_B_ISODRP])
        else $error("Dropped iso packet not flagged");

    enum_flag_a: assert property (
        (dev && evt.enum_done) |=> status_ff[UOI_B_ENUM])
        else $error("Enumeration done not flagged");

    gonak_eff_a: assert property (s_sgo_then_gap |=> out_nak_ff)
        else $error("Global OUT NAK not effective two cycles after set");

    ginak_eff_a: assert property (s_sgi_then_gap |=> in_nak_ff)
        else $error("Global IN NAK not effective two cycles after set");

    stall_first_a: assert property (
        stall_hs_ff |-> !nak_hs_ff)
        else $error("NAK handshake while stall pending");

    nptx_level_a: assert property (
        $past(rst_b) |-> status_ff[UOI_B_NPTXE]
            == ($past(host) && $past(nptx_lvl) && $past(lvl.nptx_queue_room)))
        else $error("Nonperiodic FIFO empty flag does not follow its source");

    irq_level_a: assert property (
        (status_ff & mask_ff) != 32'h00000000 |=> irq_ff)
        else $error("Interrupt low with unmasked flag set");

    irq_low_a: assert property ((status_ff & mask_ff) == 32'h00000000 |=> !irq_ff)
        else $error("Interrupt high with no unmasked flag set");

    wrong_mode_access_flag_set_a: assert property (
        (reg_rd && dev && page == UOI_HOST_PAGE) |=> status_ff[UOI_B_WRONG_MODE_ACCESS_FLAG])
        else $error("Wrong-mode access not flagged");

    susp_time_a: assert property (
        susp_hit |=> suspended_ff && status_ff[UOI_B_SUSP] && status_ff[UOI_B_EARLY_SUSPEND_FLAG])
        else $error("Suspend flags not set on idle timeout");

    susp_count_a: assert property (
        $rose(suspended_ff) |-> $past(idle_cnt_ff) == SUSP_LAST)
        else $error("Suspend entered before idle time elapsed");

endmodule : uoi_core_int

// file: tb/uoi_peer.sv
`timescale 1ns/10ps
// Bus peer: turns bench requests into event pulses, levels and line idle state
module uoi_peer
    import uoi_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [10:0] fire,
    input  wire uoi_lvl_t    hold,
    input  wire logic        idle_req,
    output uoi_evt_t         evt,
    output uoi_lvl_t         lvl,
    output logic             line_idle_pin
);
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            evt           <= '0;
            lvl           <= '0;
            line_idle_pin <= 1'b0;
        end else begin
            evt           <= uoi_evt_t'(fire);
            lvl           <= hold;
            line_idle_pin <= idle_req;
        end
    end
endmodule : uoi_peer

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
    import uoi_pkg::*;
    localparam int SUSP = 20;
    logic        clk_sys   = 1'b0;
    logic        rst_b     = 1'b0;
    logic [11:0] reg_addr  = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        id_pin    = 1'b1;
    logic        idle_req  = 1'b0;
    logic [10:0] fire      = 11'h0;
    uoi_lvl_t    hold      = '0;
    logic [31:0] reg_rdata_ff;
    uoi_evt_t    evt;
    uoi_lvl_t    lvl;
    logic        line_idle_pin, irq_ff, suspended_ff;
    logic        out_nak_ff, in_nak_ff, stall_hs_ff, nak_hs_ff;
    int          miscompares = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          s, k;
    logic [31:0] rnd = 32'h2a69;
    logic [31:0] rv;
    int          dev_e[7] = '{10, 7, 4, 3, 2, 1, 0};
    int          dev_b[7] = '{31, 30, 15, 14, 13, 12, 3};
    int          hst_e[5] = '{9, 8, 6, 5, 0};
    int          hst_b[5] = '{31, 30, 29, 21, 3};

    uoi_core_int #(.SUSP_CYCLES(SUSP)) uoi_core_int_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .id_pin(id_pin),
        .line_idle_pin(line_idle_pin), .evt(evt), .lvl(lvl), .irq_ff(irq_ff),
        .suspended_ff(suspended_ff), .out_nak_ff(out_nak_ff), .in_nak_ff(in_nak_ff),
        .stall_hs_ff(stall_hs_ff), .nak_hs_ff(nak_hs_ff));
    uoi_peer uoi_peer_i (.clk_sys(clk_sys), .rst_b(rst_b), .fire(fire), .hold(hold),
        .idle_req(idle_req), .evt(evt), .lvl(lvl), .line_idle_pin(line_idle_pin));

    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [31:0] exp_lvl(input logic h, input uoi_lvl_t l,
                                            input logic [1:0] sel);
        logic [31:0] e;
        e = 32'h0;
        e[UOI_B_ROLE] = h;
        e[UOI_B_RXNE] = l.rx_pkt_waiting;
        e[UOI_B_OTG]  = l.otg_pending;
        if (h) begin
            e[UOI_B_CHAN]  = l.chan_pending;
            e[UOI_B_PORT]  = l.port_pending;
            e[UOI_B_PTXE]  = l.ptx_queue_room & (sel[0] ? l.ptx_empty : l.ptx_half | l.ptx_empty);
            e[UOI_B_NPTXE] = l.nptx_queue_room & (sel[1] ? l.nptx_empty : l.nptx_half | l.nptx_empty);
        end else begin
            e[UOI_B_OEP] = l.out_ep_pending;
            e[UOI_B_IEP] = l.in_ep_pending;
        end
        return e;
    endfunction : exp_lvl

    task automatic print_verdict();
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_ff;
    endtask : rd

    task automatic sts(input logic [31:0] m, input logic [31:0] e);
        rd(UOI_STS_OFS, rv);
        chk_reg(rv & ~UOI_VALID_MSK, 32'h0);
        chk_reg(rv & m, e & m);
    endtask : sts

    task automatic pulse(input logic [10:0] f);
        @(posedge clk_sys);
        fire <= f;
        @(posedge clk_sys);
        fire <= 11'h0;
        repeat (2) @(posedge clk_sys);
    endtask : pulse

    task automatic ev_test(input int e, input int b);
        wr(UOI_STS_OFS, 32'hffffffff);
        pulse(11'h1 << e);
        sts(32'h1 << b, 32'h1 << b);
        rnd = xs(rnd);
        wr(UOI_STS_OFS, rnd & ~(32'h1 << b));
        sts(32'h1 << b, 32'h1 << b);
        wr(UOI_STS_OFS, 32'h1 << b);
        sts(32'h1 << b, 32'h0);
    endtask : ev_test

    task automatic lv(input logic h, input logic [1:0] sel);
        rnd = xs(rnd);
        hold <= uoi_lvl_t'(rnd[14:0]);
        wr(UOI_CTL_OFS, {30'h0, sel});
        wr(UOI_STS_OFS, 32'hffffffff);
        repeat (3) @(posedge clk_sys);
        sts(h ? 32'h07000035 : 32'h000c0015, exp_lvl(h, hold, sel));
        rd(UOI_CTL_OFS, rv);
        chk_reg(rv, {30'h0, sel});
    endtask : lv

    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        wr(UOI_STS_OFS, 32'hffffffff);
        sts(32'h1, 32'h0);
        rd(12'h100, rv);
        chk_reg(rv, 32'h0);
        foreach (dev_e[i]) ev_test(dev_e[i], dev_b[i]);
        hold.iso_out_open <= 1'b1;
        hold.iso_in_open  <= 1'b1;
        wr(UOI_STS_OFS, 32'hffffffff);
        pulse(11'h1 << 4);
        sts(32'h00308000, 32'h00308000);
        for (k = 0; k < 8; k++) lv(1'b0, k[1:0]);
        hold <= '0;
        wr(UOI_CTL_OFS, 32'h1 << UOI_C_SGO);
        repeat (3) @(posedge clk_sys);
        chk_bit(out_nak_ff, 1'b1);
        sts(32'h80, 32'h80);
        wr(UOI_CTL_OFS, 32'h1 << UOI_C_CGO);
        repeat (3) @(posedge clk_sys);
        chk_bit(out_nak_ff, 1'b0);
        wr(UOI_CTL_OFS, 32'h1 << UOI_C_SGI);
        repeat (3) @(posedge clk_sys);
        sts(32'h40, 32'h40);
        chk_bit(nak_hs_ff, 1'b1);
        hold.ep_stall <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk_bit(nak_hs_ff, 1'b0);
        chk_bit(stall_hs_ff, 1'b1);
        wr(UOI_CTL_OFS, 32'h1 << UOI_C_CGI);
        repeat (3) @(posedge clk_sys);
        chk_bit(in_nak_ff, 1'b0);
        hold <= '0;
        wr(UOI_STS_OFS, 32'hffffffff);
        @(posedge clk_sys);
        idle_req <= 1'b1;
        s = cyc;
        repeat (SUSP / 2) @(posedge clk_sys);
        sts(32'h00000c00, 32'h0);
        for (k = 0; k < 60 && suspended_ff !== 1'b1; k++) @(posedge clk_sys);
        chk_bit((cyc - s) >= SUSP && (cyc - s) <= SUSP + 6, 1'b1);
        sts(32'h00000c00, 32'h00000c00);
        idle_req <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk_bit(suspended_ff, 1'b0);
        wr(12'h400, 32'h0);
        rd(12'h400, rv);
        chk_reg(rv, 32'h0);
        sts(32'h2, 32'h2);
        wr(UOI_STS_OFS, 32'hffffffff);
        wr(UOI_MSK_OFS, 32'h8);
        rd(UOI_MSK_OFS, rv);
        chk_reg(rv, 32'h8);
        pulse(11'h1);
        @(posedge clk_sys);
        chk_bit(irq_ff, 1'b1);
        wr(UOI_MSK_OFS, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk_bit(irq_ff, 1'b0);
        wr(UOI_STS_OFS, 32'hffffffff);
        @(posedge clk_sys);
        fire <= 11'h1;
        @(posedge clk_sys);
        fire      <= 11'h0;
        reg_wr    <= 1'b1;
        reg_addr  <= UOI_STS_OFS;
        reg_wdata <= 32'h8;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        sts(32'h8, 32'h8);
        @(posedge clk_sys);
        id_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        sts(32'h10000001, 32'h10000001);
        foreach (hst_e[i]) ev_test(hst_e[i], hst_b[i]);
        for (k = 0; k < 8; k++) lv(1'b1, k[1:0]);
        wr(UOI_STS_OFS, 32'hffffffff);
        wr(12'h800, 32'h0);
        sts(32'h2, 32'h2);
        print_verdict();
    end

    initial begin
        repeat (6000) @(posedge clk_sys);
        miscompares++;
        print_verdict();
    end
endmodule : tb
